/* pkg/tcz_pkg.sv */
// Purpose: Constants and types for the 16-bit timer/counter
// Assumes: One system clock, no software-reachable registers
// Notes:   Clock select codes follow the prescaler encoding
package tcz_pkg;

  localparam int          CNT_W        = 16;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam int          SYNC_STAGES  = 3;
  localparam int          PRE_W        = 11;

  // Count clock select codes
  localparam logic [3:0]  CKS_DIV8     = 4'h1;
  localparam logic [3:0]  CKS_DIV2048  = 4'h9;
  localparam logic [3:0]  CKS_EXT      = 4'hF;

  // External edge select
  localparam logic [1:0]  EDGE_NONE    = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_FALL    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;

  // Timer output modes
  typedef enum logic [1:0] {
    TCZ_OUT_FIXED,
    TCZ_OUT_TOGGLE,
    TCZ_OUT_ONESHOT
  } tcz_out_mode_e;

endpackage : tcz_pkg

/* design/tcz_timer.sv */
// Purpose: 16-bit up-counting timer/counter, two compare, one capture
// Assumes: Control levels from same-clock logic; edge input asynchronous
// Notes:   No register bus; controls and status are plain ports
`timescale 1ns/100ps

module tcz_timer
  import tcz_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_sys_rst,
  // Control
  input  wire logic          i_count_en,
  input  wire logic [3:0]    i_clk_sel,
  input  wire logic [1:0]    i_edge_sel,
  input  wire logic          i_clear_on_b,
  input  wire logic [CW-1:0] i_compare_value_a,
  input  wire logic [CW-1:0] i_compare_value_b,
  input  wire tcz_out_mode_e i_mode_a,
  input  wire tcz_out_mode_e i_mode_b,
  input  wire logic          i_idle_level_a,
  input  wire logic          i_idle_level_b,
  input  wire logic          i_active_level_a,
  input  wire logic          i_active_level_b,
  input  wire logic          i_oneshot_trig_a,
  input  wire logic          i_oneshot_trig_b,
  // External edge pin
  input  wire logic          i_external_edge_input,
  // Status and outputs
  output logic [CW-1:0]      o_main_counter,
  output logic [CW-1:0]      o_capture_value,
  output logic               o_compare_a_interrupt,
  output logic               o_compare_b_interrupt,
  output logic               o_edge_event,
  output logic               o_timer_output_a,
  output logic               o_timer_output_b
);

  logic [SYNC_STAGES-1:0] sync_r;
  logic [PRE_W-1:0]       pre_r;
  logic [PRE_W-1:0]       pre_nxt;
  logic [CW-1:0]          cnt_r;
  logic [CW-1:0]          cnt_nxt;
  logic [CW-1:0]          cap_r;
  logic                   int_a_r;
  logic                   int_b_r;
  logic                   edge_r;
  logic                   out_a_r;
  logic                   out_b_r;

  // Valid edge decode per edge select
  function automatic logic edge_valid(input logic [1:0] sel,
                                      input logic       rise,
                                      input logic       fall);
    logic v;
    v = 1'b0;
    unique case (sel)
      EDGE_NONE: v = 1'b0;
      EDGE_RISE: v = rise;
      EDGE_FALL: v = fall;
      EDGE_BOTH: v = rise | fall;
    endcase
    return v;
  endfunction : edge_valid

  // Edge detection on differing late stages
  wire logic rise_w  = sync_r[1] & ~sync_r[2];
  wire logic fall_w  = ~sync_r[1] & sync_r[2];
  wire logic valid_w = edge_valid(i_edge_sel, rise_w, fall_w);

  // Prescaler tick select
  wire logic       sel_ok_w = i_clk_sel >= CKS_DIV8
                           && i_clk_sel <= CKS_DIV2048;
  wire logic [3:0] shift_w  = i_clk_sel + 4'h2;
  wire logic [PRE_W-1:0] mask_w =
    PRE_W'((12'h001 << shift_w) - 12'h001);
  wire logic pre_tick_w = sel_ok_w && ((pre_r & mask_w) == mask_w);
  wire logic ext_tick_w = (i_clk_sel == CKS_EXT) && valid_w;
  wire logic tick_w     = i_count_en && (pre_tick_w || ext_tick_w);

  // Compare matches, sampled on count ticks
  wire logic match_a_w = tick_w && (cnt_r == i_compare_value_a);
  wire logic match_b_w = tick_w && (cnt_r == i_compare_value_b);

  // Counter next value
  wire logic          clr_hit_w = match_b_w && i_clear_on_b;
  wire logic [CW-1:0] cnt_inc_w = cnt_r + 1'b1;

  assign pre_nxt = i_count_en ? pre_r + 1'b1 : '0;
  assign cnt_nxt = clr_hit_w ? '0 : cnt_inc_w;

  // Timer output next level per mode
  function automatic logic out_next(input tcz_out_mode_e mode,
                                    input logic cur, input logic match,
                                    input logic trig, input logic idle,
                                    input logic act);
    logic r;
    r = cur;
    unique case (mode)
      TCZ_OUT_FIXED:   r = idle;
      TCZ_OUT_TOGGLE:  r = match ? ~cur : cur;
      TCZ_OUT_ONESHOT: r = match ? ~act : (trig ? act : cur);
      default:         r = idle;
    endcase
    return r;
  endfunction : out_next

  wire logic out_a_nxt = out_next(i_mode_a, out_a_r, match_a_w,
                                  i_oneshot_trig_a, i_idle_level_a,
                                  i_active_level_a);
  wire logic out_b_nxt = out_next(i_mode_b, out_b_r, match_b_w,
                                  i_oneshot_trig_b, i_idle_level_b,
                                  i_active_level_b);

  always_ff @(posedge i_mclk) begin
    sync_r <= {sync_r[SYNC_STAGES-2:0], i_external_edge_input};
  end

  // Prescaler
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // Main counter
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cnt_r <= CNT_RESET;
    end else begin
      if (tick_w) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // Capture value
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cap_r <= CNT_RESET;
    end else if (valid_w) begin
      cap_r <= cnt_r;
    end
  end

  // Compare A interrupt
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      int_a_r <= 1'b0;
    end else begin
      int_a_r <= match_a_w;
    end
  end

  // Compare B interrupt
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      int_b_r <= 1'b0;
    end else begin
      int_b_r <= match_b_w;
    end
  end

  // Valid edge pulse
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      edge_r <= 1'b0;
    end else begin
      edge_r <= valid_w;
    end
  end

  // Timer output A
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      out_a_r <= 1'b0;
    end else begin
      out_a_r <= out_a_nxt;
    end
  end

  // Timer output B
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      out_b_r <= 1'b0;
    end else begin
      out_b_r <= out_b_nxt;
    end
  end

  assign o_main_counter        = cnt_r;
  assign o_capture_value       = cap_r;
  assign o_compare_a_interrupt = int_a_r;
  assign o_compare_b_interrupt = int_b_r;
  assign o_edge_event          = edge_r;
  assign o_timer_output_a      = out_a_r;
  assign o_timer_output_b      = out_b_r;

endmodule : tcz_timer

/* sim/tcz_timer_sva.sv */
// Purpose: Port checker for the timer/counter
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto every timer instance
`timescale 1ns/100ps
module tcz_timer_sva import tcz_pkg::*; #(parameter int CW = CNT_W) (
  input wire logic i_mclk, i_sys_rst, i_count_en, i_clear_on_b,
  input wire logic i_oneshot_trig_b, i_active_level_b, o_compare_b_interrupt,
  input wire logic o_edge_event, o_timer_output_a, o_compare_a_interrupt,
  input wire logic o_timer_output_b,
  input wire logic [CW-1:0] i_compare_value_b, o_main_counter, o_capture_value,
  input wire tcz_out_mode_e i_mode_a, i_mode_b);
  wire os = i_mode_b == TCZ_OUT_ONESHOT;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_reset_clear: assert property (
    disable iff (1'b0) i_sys_rst |=> o_main_counter == '0 &&
    o_capture_value == '0) else $error("no reset clear");
  a_hold_stopped: assert property (
    !i_count_en |=> $stable(o_main_counter)) else $error("moved when stopped");
  a_count_step: assert property ($changed(o_main_counter) |->
    o_main_counter == $past(o_main_counter) + 1'b1 || o_main_counter == '0)
    else $error("bad count step");
  a_match_b: assert property (o_compare_b_interrupt |->
    o_main_counter == (i_clear_on_b ? '0 : i_compare_value_b + 1'b1))
    else $error("bad match b");
  a_capture_cause: assert property (
    $changed(o_capture_value) |-> o_edge_event) else $error("stray capture");
  a_toggle_a: assert property (i_mode_a == TCZ_OUT_TOGGLE &&
    $past(i_mode_a) == TCZ_OUT_TOGGLE |-> $changed(o_timer_output_a) ==
    o_compare_a_interrupt) else $error("bad toggle a");
  a_oneshot_start: assert property (os && i_oneshot_trig_b |->
    ##[1:2] o_timer_output_b == i_active_level_b) else $error("no shot start");
  a_oneshot_end: assert property (os && $past(os) &&
    o_compare_b_interrupt |-> o_timer_output_b != i_active_level_b)
    else $error("no shot end");
endmodule : tcz_timer_sva
bind tcz_timer tcz_timer_sva #(.CW(CW)) u_sva (.*);

/* sim/tcz_pulse_src.sv */
// Purpose: External pulse source on the edge pin
// Assumes: Bench calls pulse with a count
// Notes:   Idles low between bursts
`timescale 1ns/100ps
module tcz_pulse_src (input wire logic i_mclk, output logic o_pin);
  initial o_pin = 1'b0;
  task automatic pulse(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge i_mclk);
      #1 o_pin = !o_pin;
    end
  endtask : pulse
endmodule : tcz_pulse_src

/* sim/tb_tcz_timer.sv */
// Purpose: Self-checking bench for the timer/counter
// Assumes: 20 MHz clock, synchronous reset
// Notes:   Interval periods checked by a watcher
`timescale 1ns/100ps
module tb_tcz_timer;
  import tcz_pkg::*;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, clr = 1'b0, trb = 1'b0, alb = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [1:0] es = 2'h0;
  logic [15:0] ca = 16'h0000, cb = 16'h0000, cnt, cap;
  tcz_out_mode_e mb = TCZ_OUT_FIXED;
  logic ia, ib, ev, ta, tb, pin;
  int miscompares = 0, samples_checked = 0, seed = 32'h526990bf;
  int cyc = 0, last = -1, n;
  int q[$];
  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tcz_pulse_src src (.i_mclk(clk), .o_pin(pin));
  tcz_timer dut (.i_mclk(clk), .i_sys_rst(rst), .i_count_en(en),
    .i_clk_sel(sel), .i_edge_sel(es), .i_clear_on_b(clr),
    .i_compare_value_a(ca), .i_compare_value_b(cb), .i_mode_a(TCZ_OUT_TOGGLE),
    .i_mode_b(mb), .i_idle_level_a(1'b0), .i_idle_level_b(1'b0),
    .i_active_level_a(1'b1), .i_active_level_b(alb), .i_oneshot_trig_a(1'b0),
    .i_oneshot_trig_b(trb), .i_external_edge_input(pin), .o_main_counter(cnt),
    .o_capture_value(cap), .o_compare_a_interrupt(ia),
    .o_compare_b_interrupt(ib), .o_edge_event(ev), .o_timer_output_a(ta),
    .o_timer_output_b(tb));
  task automatic chk(input string nm, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk) if (rst) last <= -1; else if (ib) begin
    if (last >= 0 && q.size() > 0)
      chk("period", 16'(cyc - last), 16'(q.pop_front()));
    last <= cyc;
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    chk("counter", cnt, 16'h0000);
    for (int k = 1; k <= 9; k++) begin
      @(posedge clk) #1 rst = 1'b1;
      sel = 4'(k); clr = 1'b1; en = 1'b1; mb = TCZ_OUT_ONESHOT; alb = k[0];
      cb = 16'(2 + $unsigned($random(seed)) % 3);
      ca = cb - 16'h0001;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0; trb = 1'b1;
      q.push_back((int'(cb) + 1) << (k + 2));
      @(posedge clk) #1 trb = 1'b0;
      for (n = 0; q.size() > 0 && n < 30000; n++) @(posedge clk);
      if (q.size() > 0) begin
        miscompares++;
        q.delete();
        break;
      end
      chk("oneshot", 16'(tb), 16'(!alb));
      $display("interval test %0d done", k);
    end
    for (int e = 1; e <= 3; e++) begin
      @(posedge clk) #1 rst = 1'b1;
      sel = CKS_EXT; clr = 1'b0; es = 2'(e); mb = TCZ_OUT_FIXED; en = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      n = 1 + $unsigned($random(seed)) % 20;
      src.pulse(2);
      repeat (8) @(posedge clk);
      #1 chk("held", cnt, 16'h0000);
      en = 1'b1;
      src.pulse(n);
      repeat (8) @(posedge clk);
      #1 chk("events", cnt, 16'(e == 3 ? 2 * n : n));
      chk("capture", cap, 16'(e == 3 ? 2 * n - 1 : n - 1));
      $display("event test %0d done", e);
    end
    wrap_up();
  end
endmodule : tb_tcz_timer
